/* design/pg_params.svh */
`ifndef PG_PARAMS_SVH
`define PG_PARAMS_SVH

// register offsets
`define PG_MODE_ADDR      8'h17
`define PG_A_SEL_ADDR     8'h18
`define PG_A_FAULT_ADDR   8'h19
`define PG_B_SEL_ADDR     8'h1A
`define PG_B_FAULT_ADDR   8'h1B

// field positions in the mode register
`define PG_MODE_B_GATED   6
`define PG_MODE_A_GATED   2

// reset values
`define PG_SEL_RESET      8'h00
`define PG_FAULT_RESET    7'h00
`define PG_MODE_RESET     2'h0

// timing
`define PG_CLK_KHZ        50000
`define PG_RISE_DELAY_MS  11
`define PG_RISE_DELAY_CYC (`PG_RISE_DELAY_MS * `PG_CLK_KHZ)
`define PG_CNT_W          20

`endif

/* design/pg_pkg.sv */
package pg_pkg;

   // one bit per monitored source, msb first as in the registers
   typedef struct packed {
      logic thermal_warning;
      logic analog_supply;
      logic ext_monitor_two;
      logic ext_monitor_one;
      logic boost;
      logic step_down_second;
      logic step_down_first;
   } src_s;

   typedef struct packed {
      logic rise_delay_en;
      src_s use_src;
   } sel_s;

   typedef struct packed {
      logic b_fault_gated_mode;
      logic a_fault_gated_mode;
   } mode_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;

endpackage : pg_pkg

/* design/power_good_fault_latching.sv */
// What this block does
// RULE1 - first output thermal latch, bit 6, set when selected thermal drops output
// RULE2 - first output analog latch, bit 5, set when selected analog drops output
// RULE3 - first output monitor-two latch, bit 4, set when selected source drops output
// RULE4 - first output monitor-one latch, bit 3, set when selected source drops output
// RULE5 - first output boost latch, bit 2, set when selected boost drops output
// RULE6 - first output second-buck latch, bit 1, set when selected source drops it
// RULE7 - first output first-buck latch, bit 0, set when selected source drops it
// RULE8 - latch stays set; write one clears only while its source is valid
// RULE9 - second output bit 7 delays its rise by 11 ms; zero means none
// RULE10 - second output select bit 6 includes thermal warning; zero masks it
// RULE11 - second output select bit 5 includes analog supply; zero masks it
// RULE12 - second output select bit 4 includes monitor two; zero masks it
// RULE13 - second output select bit 3 includes monitor one; zero masks it
// RULE14 - second output select bit 2 includes boost; zero masks it
// RULE15 - second output select bit 1 includes second buck; zero masks it
// RULE16 - second output select bit 0 includes first buck; zero masks it
// RULE17 - after reset the select bits load from one-time configuration memory
// RULE18 - second output fault latches behave like the first output's
// RULE19 - live mode output follows current validity of selected sources
// RULE20 - fault-gated mode output stays inactive while any latch is set
// RULE21 - first output has its own seven select bits, one includes
// RULE22 - live output valid only when all selected sources valid; masked ignored
// RULE23 - reserved bit 7 of each fault register reads zero, ignores writes
`timescale 1ns/100ps
`include "pg_params.svh"


////////////////////////////////////////////////////////////////////////////////
// rise delay stage, one per output

module pg_rise_delay #(
   parameter logic [`PG_CNT_W-1:0] DELAY_CYC = `PG_CNT_W'(`PG_RISE_DELAY_CYC)
) (
   input  wire logic clk,  // system clock
   input  wire logic rstn, // async reset, active low
   input  wire logic raw,  // undelayed power-good
   input  wire logic en,   // rise delay enable
   output logic      out   // delayed power-good
);
   logic [`PG_CNT_W-1:0] cnt;
   logic [`PG_CNT_W-1:0] next_cnt;
   logic                 next_out;

   always_comb
   begin
      next_cnt = cnt;
      next_out = out;
      if (!raw)
      begin
         next_cnt = '0;
         next_out = 1'b0;
      end
      else if (!en)
      begin
         next_out = 1'b1;
      end
      else if (!out)
      begin
         // rise only after the full delay with raw held high
         if (cnt == DELAY_CYC - `PG_CNT_W'(1))
            next_out = 1'b1;
         else
            next_cnt = cnt + `PG_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt <= '0;
         out <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         out <= next_out;
      end
   end
endmodule : pg_rise_delay

////////////////////////////////////////////////////////////////////////////////
// top

module power_good_fault_latching #(
   parameter logic [`PG_CNT_W-1:0] RISE_DELAY_CYCLES =
      `PG_CNT_W'(`PG_RISE_DELAY_CYC)
) (
   input  wire logic            clk,              // 50 MHz clock
   input  wire logic            rstn,             // async reset, active low
   input  wire pg_pkg::bus_req_s bus,             // register request
   output logic [7:0]           rdata,            // read data, next cycle
   input  wire pg_pkg::src_s    source_valid,     // source valid pins
   input  wire pg_pkg::sel_s    otp_sel_a,        // default first select
   input  wire pg_pkg::sel_s    otp_sel_b,        // default second select
   input  wire pg_pkg::mode_s   otp_mode,         // default modes
   output logic                 power_good_out_a, // first power-good
   output logic                 power_good_out_b  // second power-good
);
   import pg_pkg::*;

   /////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   src_s vld_meta;
   src_s vld;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // read valid until the pins arrive: no false latch
         vld_meta <= '1;
         vld      <= '1;
      end
      else
      begin
         vld_meta <= source_valid;
         vld      <= vld_meta;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // registers

   sel_s       sel_a;
   sel_s       sel_b;
   mode_s      mode;
   src_s       fault_a;
   src_s       fault_b;
   logic       otp_loaded;
   logic [7:0] rdata_q;
   sel_s       next_sel_a;
   sel_s       next_sel_b;
   mode_s      next_mode;
   src_s       next_fault_a;
   src_s       next_fault_b;
   logic       next_otp_loaded;
   logic [7:0] next_rdata;
   src_s       set_a;
   src_s       set_b;
   src_s       clr_a;
   src_s       clr_b;
   logic       wr_ok;

   always_comb
   begin
      wr_ok = bus.wr && otp_loaded;
      // masked sources never latch
      set_a = sel_a.use_src & ~vld;
      set_b = sel_b.use_src & ~vld;
      // clear only where the source is valid again
      clr_a = (wr_ok && bus.addr == `PG_A_FAULT_ADDR) ?       // RULE8
              src_s'(bus.wdata[6:0]) & vld : '0;
      clr_b = (wr_ok && bus.addr == `PG_B_FAULT_ADDR) ?
              src_s'(bus.wdata[6:0]) & vld : '0;

      next_sel_a      = sel_a;
      next_sel_b      = sel_b;
      next_mode       = mode;
      next_otp_loaded = 1'b1;
      if (!otp_loaded)
      begin
         next_sel_a = otp_sel_a;                             // RULE17
         next_sel_b = otp_sel_b;                             // RULE17
         next_mode  = otp_mode;
      end
      else if (wr_ok)
      begin
         case (bus.addr)
            `PG_A_SEL_ADDR: next_sel_a = sel_s'(bus.wdata);  // RULE21
            `PG_B_SEL_ADDR: next_sel_b = sel_s'(bus.wdata);
            `PG_MODE_ADDR:
            begin
               next_mode.a_fault_gated_mode = bus.wdata[`PG_MODE_A_GATED];
               next_mode.b_fault_gated_mode = bus.wdata[`PG_MODE_B_GATED];
            end
            default: ;
         endcase
      end

      // set wins over clear
      next_fault_a = fault_a & ~clr_a;
      next_fault_a.thermal_warning  = fault_a.thermal_warning
         & ~clr_a.thermal_warning | set_a.thermal_warning;   // RULE1
      next_fault_a.analog_supply    = fault_a.analog_supply
         & ~clr_a.analog_supply | set_a.analog_supply;       // RULE2
      next_fault_a.ext_monitor_two  = fault_a.ext_monitor_two
         & ~clr_a.ext_monitor_two | set_a.ext_monitor_two;   // RULE3
      next_fault_a.ext_monitor_one  = fault_a.ext_monitor_one
         & ~clr_a.ext_monitor_one | set_a.ext_monitor_one;   // RULE4
      next_fault_a.boost            = fault_a.boost
         & ~clr_a.boost | set_a.boost;                       // RULE5
      next_fault_a.step_down_second = fault_a.step_down_second
         & ~clr_a.step_down_second | set_a.step_down_second; // RULE6
      next_fault_a.step_down_first  = fault_a.step_down_first
         & ~clr_a.step_down_first | set_a.step_down_first;   // RULE7
      next_fault_b = fault_b & ~clr_b | set_b;               // RULE18

      next_rdata = 8'h00;
      if (bus.rd)
      begin
         case (bus.addr)
            `PG_MODE_ADDR:
            begin
               next_rdata[`PG_MODE_A_GATED] = mode.a_fault_gated_mode;
               next_rdata[`PG_MODE_B_GATED] = mode.b_fault_gated_mode;
            end
            `PG_A_SEL_ADDR:   next_rdata = sel_a;
            `PG_B_SEL_ADDR:   next_rdata = sel_b;
            `PG_A_FAULT_ADDR: next_rdata = {1'b0, fault_a};   // RULE23
            `PG_B_FAULT_ADDR: next_rdata = {1'b0, fault_b};   // RULE23
            default:          next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sel_a      <= `PG_SEL_RESET;
         sel_b      <= `PG_SEL_RESET;
         mode       <= `PG_MODE_RESET;
         fault_a    <= `PG_FAULT_RESET;
         fault_b    <= `PG_FAULT_RESET;
         otp_loaded <= 1'b0;
         rdata_q    <= 8'h00;
      end
      else
      begin
         sel_a      <= next_sel_a;
         sel_b      <= next_sel_b;
         mode       <= next_mode;
         fault_a    <= next_fault_a;
         fault_b    <= next_fault_b;
         otp_loaded <= next_otp_loaded;
         rdata_q    <= next_rdata;
      end
   end

   assign rdata = rdata_q;

   /////////////////////////////////////////////////////////////////////////////
   // power-good combination

   logic live_a;
   logic live_b;
   logic raw_a;
   logic raw_b;

   always_comb
   begin
      live_a = &(vld | ~sel_a.use_src);                      // RULE22
      live_b = (vld.thermal_warning  | ~sel_b.use_src.thermal_warning)  // RULE10
             & (vld.analog_supply    | ~sel_b.use_src.analog_supply)    // RULE11
             & (vld.ext_monitor_two  | ~sel_b.use_src.ext_monitor_two)  // RULE12
             & (vld.ext_monitor_one  | ~sel_b.use_src.ext_monitor_one)  // RULE13
             & (vld.boost            | ~sel_b.use_src.boost)            // RULE14
             & (vld.step_down_second | ~sel_b.use_src.step_down_second) // RULE15
             & (vld.step_down_first  | ~sel_b.use_src.step_down_first); // RULE16
      raw_a = mode.a_fault_gated_mode ? ~|fault_a : live_a;  // RULE19
      raw_b = mode.b_fault_gated_mode ? ~|fault_b : live_b;  // RULE20
   end

   pg_rise_delay #(.DELAY_CYC(RISE_DELAY_CYCLES)) u_delay_a (
      .clk  (clk),
      .rstn (rstn),
      .raw  (raw_a),
      .en   (sel_a.rise_delay_en),
      .out  (power_good_out_a)
   );

   pg_rise_delay #(.DELAY_CYC(RISE_DELAY_CYCLES)) u_delay_b (
      .clk  (clk),
      .rstn (rstn),
      .raw  (raw_b),
      .en   (sel_b.rise_delay_en),                           // RULE9
      .out  (power_good_out_b)
   );

   /////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_latch_set_a: assert property ( // RULE1
      |(sel_a.use_src & ~vld) |=>
         (fault_a & $past(sel_a.use_src & ~vld))
            == $past(sel_a.use_src & ~vld))
      else $error("first output latch missed a fault");

   b_latch_set_a: assert property ( // RULE18
      |(sel_b.use_src & ~vld) |=>
         (fault_b & $past(sel_b.use_src & ~vld))
            == $past(sel_b.use_src & ~vld))
      else $error("second output latch missed a fault");

   latch_hold_a: assert property ( // RULE8
      |fault_a |=> (fault_a & $past(fault_a & ~clr_a))
         == $past(fault_a & ~clr_a))
      else $error("fault latch dropped without a valid clear");

   latch_clear_a: assert property ( // RULE8
      |clr_b |=> (fault_b & $past(clr_b)) == 7'h00)
      else $error("fault latch not cleared by write one");

   masked_free_a: assert property ( // RULE22
      otp_loaded && sel_a.use_src == 7'h00 && !sel_a.rise_delay_en
         && !mode.a_fault_gated_mode |=> power_good_out_a)
      else $error("masked sources affected first output");

   gated_low_a: assert property ( // RULE20
      mode.b_fault_gated_mode && |fault_b |=> !power_good_out_b)
      else $error("gated output active with a fault latched");

   live_drop_a: assert property ( // RULE19
      !mode.b_fault_gated_mode && !live_b |=> !power_good_out_b)
      else $error("live output active with a source invalid");

   no_delay_a: assert property ( // RULE9
      otp_loaded && !sel_b.rise_delay_en && raw_b
         |=> power_good_out_b)
      else $error("second output rise delayed while disabled");

   rise_wait_a: assert property ( // RULE9
      sel_b.rise_delay_en && !power_good_out_b && $rose(raw_b)
         |=> !power_good_out_b)
      else $error("second output rose before the delay");

   reserved_zero_a: assert property ( // RULE23
      bus.rd && bus.addr == `PG_A_FAULT_ADDR |=> rdata[7] == 1'b0
         && rdata[6:0] == $past(fault_a))
      else $error("fault register read wrong");

   otp_load_a: assert property ( // RULE17
      rstn && !otp_loaded |=> sel_b == $past(otp_sel_b)
         && sel_a == $past(otp_sel_a))
      else $error("select defaults not loaded after reset");

endmodule : power_good_fault_latching

/* tb/pg_watcher.sv */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// reset logic watching the power-good pins: counts every drop

module pg_watcher (
   input  wire logic        clk,     // system clock
   input  wire logic        rstn,    // async reset, active low
   input  wire logic        pg_a,    // first power-good pin
   input  wire logic        pg_b,    // second power-good pin
   output logic [15:0]      drops_a, // falls seen on first pin
   output logic [15:0]      drops_b  // falls seen on second pin
);
   logic        prev_a;
   logic        prev_b;
   logic [15:0] next_drops_a;
   logic [15:0] next_drops_b;

   always_comb
   begin
      next_drops_a = drops_a + 16'(prev_a & ~pg_a);
      next_drops_b = drops_b + 16'(prev_b & ~pg_b);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prev_a  <= 1'b0;
         prev_b  <= 1'b0;
         drops_a <= 16'h0000;
         drops_b <= 16'h0000;
      end
      else
      begin
         prev_a  <= pg_a;
         prev_b  <= pg_b;
         drops_a <= next_drops_a;
         drops_b <= next_drops_b;
      end
   end
endmodule : pg_watcher

/* tb/power_good_fault_latching_tb_top.sv */
`timescale 1ns/100ps
`include "pg_params.svh"

module power_good_fault_latching_tb_top;
   import pg_pkg::*;

   localparam int RD = 8;

   logic       clk;
   logic       rstn;
   bus_req_s   bus;
   logic [7:0] rdata;
   src_s       sv;
   sel_s       osa;
   sel_s       osb;
   mode_s      om;
   logic       pa;
   logic       pb;
   logic [15:0] da;
   logic [15:0] db;
   logic [7:0] sa;
   logic [7:0] sb;
   logic [7:0] v;
   int         n;
   int         failures;
   int         cmp_count;

   power_good_fault_latching #(
      .RISE_DELAY_CYCLES(`PG_CNT_W'(RD))
   ) u_dut (
      .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
      .source_valid(sv), .otp_sel_a(osa), .otp_sel_b(osb),
      .otp_mode(om), .power_good_out_a(pa), .power_good_out_b(pb)
   );

   pg_watcher u_watch (
      .clk(clk), .rstn(rstn), .pg_a(pa), .pg_b(pb),
      .drops_a(da), .drops_b(db)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   /////////////////////////////////////////////////////////////////////////////
   // shared tasks

   task automatic print_verdict();
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h want %h", $time, got, exp);
         failures++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : chk_rd

   // pins pass the synchroniser, then latch and output settle
   task automatic src(input logic [6:0] x);
      @(posedge clk);
      sv <= src_s'(x);
      repeat (5) @(posedge clk);
   endtask : src

   function automatic logic [7:0] fault_of(logic [7:0] s, logic [7:0] x);
      return {1'b0, s[6:0] & ~x[6:0]};
   endfunction : fault_of

   function automatic logic [7:0] good_of(logic [7:0] s, logic [7:0] x);
      return {7'h00, &(x[6:0] | ~s[6:0])};
   endfunction : good_of

   task automatic rise(input logic [7:0] s, input int lo, input int hi);
      wr(`PG_B_SEL_ADDR, s);
      src(7'h7E);
      chk({7'h00, pb}, 8'h00);
      @(posedge clk);
      sv <= src_s'(7'h7F);
      for (n = 0; n < 40 && pb !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      if (n == 40)
      begin
         failures++;
         print_verdict();
      end
      chk({7'h00, n >= lo && n <= hi}, 8'h01);
      wr(`PG_B_FAULT_ADDR, 8'hFF);
   endtask : rise

   /////////////////////////////////////////////////////////////////////////////
   // main sequence

   initial
   begin
      failures  = 0;
      cmp_count = 0;
      rstn      = 1'b0;
      bus       = '0;
      sv        = src_s'(7'h7F);
      void'($urandom(32'h0545a6c7));
      osa = sel_s'($urandom);
      osb = sel_s'($urandom);
      om  = mode_s'($urandom);
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      chk_rd(`PG_A_SEL_ADDR, osa);
      chk_rd(`PG_B_SEL_ADDR, osb);
      chk_rd(`PG_MODE_ADDR, {1'b0, om.b_fault_gated_mode, 3'h0,
             om.a_fault_gated_mode, 2'h0});
      chk_rd(`PG_A_FAULT_ADDR, 8'h00);
      chk_rd(`PG_B_FAULT_ADDR, 8'h00);
      wr(8'h20, 8'hFF);
      chk_rd(8'h20, 8'h00);
      wr(`PG_MODE_ADDR, {1'b0, om.b_fault_gated_mode, 6'h00});
      chk_rd(`PG_MODE_ADDR, {1'b0, om.b_fault_gated_mode, 6'h00});
      // live mode, random selects and sources
      for (int i = 0; i < 14; i++)
      begin
         src(7'h7F);
         wr(`PG_MODE_ADDR, 8'h00);
         sa = 8'($urandom) & 8'h7F;
         sb = 8'($urandom) & 8'h7F;
         v  = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($urandom);
         wr(`PG_A_SEL_ADDR, sa);
         wr(`PG_B_SEL_ADDR, sb);
         wr(`PG_A_FAULT_ADDR, 8'hFF);
         wr(`PG_B_FAULT_ADDR, 8'hFF);
         chk_rd(`PG_A_SEL_ADDR, sa);
         chk_rd(`PG_B_SEL_ADDR, sb);
         src(v[6:0]);
         chk_rd(`PG_A_FAULT_ADDR, fault_of(sa, v));
         chk_rd(`PG_B_FAULT_ADDR, fault_of(sb, v));
         chk({7'h00, pa}, good_of(sa, v));
         chk({7'h00, pb}, good_of(sb, v));
      end
      // sticky latch, refused and accepted clears on both outputs
      for (int k = 0; k < 2; k++)
      begin
         src(7'h7F);
         wr(`PG_A_SEL_ADDR + 8'(2 * k), 8'h01);
         wr(`PG_A_FAULT_ADDR + 8'(2 * k), 8'hFF);
         src(7'h7E);
         wr(`PG_A_FAULT_ADDR + 8'(2 * k), 8'h01);
         chk_rd(`PG_A_FAULT_ADDR + 8'(2 * k), 8'h01);
         src(7'h7F);
         chk_rd(`PG_A_FAULT_ADDR + 8'(2 * k), 8'h01);
         wr(`PG_A_FAULT_ADDR + 8'(2 * k), 8'h01);
         chk_rd(`PG_A_FAULT_ADDR + 8'(2 * k), 8'h00);
      end
      // fault-gated mode holds outputs low until cleared
      wr(`PG_MODE_ADDR, 8'h44);
      wr(`PG_A_SEL_ADDR, 8'h01);
      wr(`PG_B_SEL_ADDR, 8'h02);
      src(7'h7C);
      src(7'h7F);
      chk({6'h00, pa, pb}, 8'h00);
      wr(`PG_A_FAULT_ADDR, 8'hFF);
      wr(`PG_B_FAULT_ADDR, 8'hFF);
      repeat (4) @(posedge clk);
      chk({6'h00, pa, pb}, 8'h03);
      wr(`PG_MODE_ADDR, 8'h00);
      rise(8'h01, 1, 5);
      rise(8'h81, RD, RD + 5);
      chk({7'h00, da != 16'h0000 && db != 16'h0000}, 8'h01);
      print_verdict();
   end
endmodule : power_good_fault_latching_tb_top
